// ### src/ppt_regs.svh
`ifndef PPT_REGS_SVH
`define PPT_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PPT_OFF_CONTROL     8'h00
`define PPT_OFF_TARGET      8'h04
`define PPT_OFF_WRAP_MODE   8'h08
`define PPT_OFF_WRAP_ENABLE 8'h0c
`define PPT_OFF_WRAP_RANGE  8'h10
`define PPT_OFF_WRAP_OFFSET 8'h14
`define PPT_OFF_STATUS      8'h18
`define PPT_OFF_ENDPOINT    8'h1c
`define PPT_OFF_TRAVEL      8'h20

// ----------------------------------------------------------------------
// Control word bit positions
// ----------------------------------------------------------------------
`define PPT_CTL_NEW_SETPOINT 4
`define PPT_CTL_RELATIVE     6
`define PPT_CTL_BASE_ACTUAL  12
`define PPT_CTL_PUSH         13
`define PPT_CTL_WRAP         14

// ----------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------
`define PPT_STS_BUSY       0
`define PPT_STS_DONE       1
`define PPT_STS_FORWARD    2
`define PPT_STS_ERROR      3
`define PPT_STS_OUT_WINDOW 4
`define PPT_STS_ACTUAL     5

// ----------------------------------------------------------------------
// Reset values and scale divisors
// ----------------------------------------------------------------------
`define PPT_RST_CONTROL     16'h0000
`define PPT_RST_TARGET      32'h0000_0000
`define PPT_RST_WRAP_MODE   2'h0
`define PPT_RST_WRAP_ENABLE 1'h0
`define PPT_RST_WRAP_RANGE  16'h000a
`define PPT_RST_WRAP_OFFSET 16'h1388
`define PPT_RANGE_DIVISOR   48'h0000_0000_000a
`define PPT_RATIO_DIVISOR   48'h0000_0000_2710

`endif

// ### src/ppt_pkg.sv
package ppt_pkg;

	typedef enum logic [6:0] {
		PPT_IDLE   = 7'b000_0001,
		PPT_RANGE  = 7'b000_0010,
		PPT_OFFS   = 7'b000_0100,
		PPT_CUR    = 7'b000_1000,
		PPT_TGT    = 7'b001_0000,
		PPT_RESULT = 7'b010_0000,
		PPT_FAIL   = 7'b100_0000
	} ppt_state_t;

	typedef enum logic [1:0] {
		PPT_WRAP_ABSOLUTE = 2'h0,
		PPT_WRAP_SHORTEST = 2'h1,
		PPT_WRAP_FORWARD  = 2'h2,
		PPT_WRAP_REVERSE  = 2'h3
	} ppt_wrap_mode_t;

	typedef logic signed [47:0] ppt_wide_t;

endpackage : ppt_pkg

// ### src/ppt_divu.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Unsigned restoring divider, one quotient bit per clock
// ----------------------------------------------------------------------
module ppt_divu #(
	parameter int W = 48
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [W-1:0] divisor,
	output logic              done,
	output logic [W-1:0]      quotient,
	output logic [W-1:0]      remainder
);

	logic [W-1:0] quo_reg;
	logic [W-1:0] rem_reg;
	logic [W-1:0] div_reg;
	logic [7:0]   cnt_reg;
	logic         run_reg;
	logic         done_reg;
	logic [W:0]   trial;

	assign trial     = {rem_reg, quo_reg[W-1]} - {1'b0, div_reg};
	assign done      = done_reg;
	assign quotient  = quo_reg;
	assign remainder = rem_reg;

	// A zero divisor yields an all-ones quotient; callers screen it out.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			quo_reg  <= '0;
			rem_reg  <= '0;
			div_reg  <= '0;
			cnt_reg  <= 8'h00;
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (start) begin
				quo_reg <= dividend;
				rem_reg <= '0;
				div_reg <= divisor;
				cnt_reg <= 8'(W);
				run_reg <= 1'b1;
			end else if (run_reg) begin
				if (!trial[W]) begin
					rem_reg <= trial[W-1:0];
					quo_reg <= {quo_reg[W-2:0], 1'b1};
				end else begin
					rem_reg <= {rem_reg[W-2:0], quo_reg[W-1]};
					quo_reg <= {quo_reg[W-2:0], 1'b0};
				end
				cnt_reg <= cnt_reg - 8'h01;
				if (cnt_reg == 8'h01) begin
					run_reg  <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end

endmodule : ppt_divu

// ### src/ppt_core.sv
`timescale 1ns/10ps
`include "ppt_regs.svh"

// Behaviour
// - A move starts when software writes the control word with the new-setpoint bit going from 0 to 1, and target and mode bits except push are latched then.
// - With the wrap bit set the move is absolute inside the wrap range and the relative bit is ignored.
// - Without wrap, a set relative bit uses the base bit to pick the command position (0) or actual position (1) as reference.
// - Command-based incremental moves end at the command position plus the signed target amount.
// - Actual-based incremental moves end at the actual position plus the signed target amount.
// - After an actual-based move the command and actual positions both land on start actual position plus the amount.
// - The actual position may serve as reference even when it differs from the command position.
// - Wrap absolute moves go to the window coordinate with direction set by the coordinates alone.
// - Wrap shortest moves take whichever direction reaches the coordinate over the shorter distance.
// - Wrap forward moves always travel forward, wrapping round the range if needed.
// - Wrap reverse moves always travel in reverse, wrapping round the range if needed.
// - Wrap mode 0 is absolute, 1 shortest, 2 forward and 3 reverse.
// - The wrap range counts in tenths of a revolution.
// - The offset ratio counts in hundredths of a percent of the range.
module ppt_core #(
	parameter int STEPS_PER_REV = 10000
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [31:0] cmd_pos,
	input  wire logic [31:0] act_pos,
	output logic             move_start,
	output logic      [31:0] move_endpoint,
	output logic      [31:0] move_travel,
	output logic             move_forward,
	output logic             move_push,
	output logic             move_rebase,
	output logic      [31:0] move_rebase_pos,
	output logic             move_busy
);

	import ppt_pkg::*;

	// ------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------
	logic [15:0]    control_reg;
	logic [31:0]    target_reg;
	ppt_wrap_mode_t wrap_mode_reg;
	logic           wrap_enable_reg;
	logic [15:0]    wrap_range_reg;
	logic [15:0]    wrap_offset_reg;
	logic           done_reg;
	logic           error_reg;
	logic           out_window_reg;
	logic           start_evt;
	logic           done_set;
	logic           error_set;
	logic           window_set;
	logic           sts_clear;

	// Starting while a move is being worked out is ignored so the latched set stays coherent.
	assign start_evt = reg_wr && (reg_addr == `PPT_OFF_CONTROL) && reg_wdata[`PPT_CTL_NEW_SETPOINT]
	                   && !control_reg[`PPT_CTL_NEW_SETPOINT] && !move_busy;
	assign sts_clear = reg_wr && (reg_addr == `PPT_OFF_STATUS);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			control_reg     <= `PPT_RST_CONTROL;
			target_reg      <= `PPT_RST_TARGET;
			wrap_mode_reg   <= ppt_wrap_mode_t'(`PPT_RST_WRAP_MODE);
			wrap_enable_reg <= `PPT_RST_WRAP_ENABLE;
			wrap_range_reg  <= `PPT_RST_WRAP_RANGE;
			wrap_offset_reg <= `PPT_RST_WRAP_OFFSET;
		end else if (reg_wr) begin
			if (reg_addr == `PPT_OFF_CONTROL) begin
				control_reg <= reg_wdata[15:0];
			end else if (reg_addr == `PPT_OFF_TARGET) begin
				target_reg <= reg_wdata;
			end else if (reg_addr == `PPT_OFF_WRAP_MODE) begin
				wrap_mode_reg <= ppt_wrap_mode_t'(reg_wdata[1:0]);
			end else if (reg_addr == `PPT_OFF_WRAP_ENABLE) begin
				wrap_enable_reg <= reg_wdata[0];
			end else if (reg_addr == `PPT_OFF_WRAP_RANGE) begin
				wrap_range_reg <= reg_wdata[15:0];
			end else if (reg_addr == `PPT_OFF_WRAP_OFFSET) begin
				wrap_offset_reg <= reg_wdata[15:0];
			end
		end
	end

	// Sticky flags: a write of 1 clears a bit, but a set in the same cycle wins.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			done_reg       <= 1'b0;
			error_reg      <= 1'b0;
			out_window_reg <= 1'b0;
		end else begin
			done_reg       <= done_set || (done_reg && !(sts_clear && reg_wdata[`PPT_STS_DONE]));
			error_reg      <= error_set || (error_reg && !(sts_clear && reg_wdata[`PPT_STS_ERROR]));
			out_window_reg <= window_set || (out_window_reg && !(sts_clear && reg_wdata[`PPT_STS_OUT_WINDOW]));
		end
	end

	// ------------------------------------------------------------------
	// Move computation
	// ------------------------------------------------------------------
	ppt_state_t     state_reg;
	logic           relative_l_reg;
	logic           base_act_l_reg;
	logic           wrap_l_reg;
	ppt_wrap_mode_t mode_l_reg;
	ppt_wide_t      target_l_reg;
	ppt_wide_t      cmd_l_reg;
	ppt_wide_t      act_l_reg;
	ppt_wide_t      range_reg;
	ppt_wide_t      offs_reg;
	ppt_wide_t      cur_in_reg;
	ppt_wide_t      tgt_in_reg;
	logic           neg_reg;
	logic           div_go_reg;
	logic [47:0]    dividend_reg;
	logic [47:0]    divisor_reg;
	logic           div_done;
	logic [47:0]    div_quo;
	logic [47:0]    div_rem;
	ppt_wide_t      folded;
	ppt_wide_t      tgt_shift;
	ppt_wide_t      cmd_shift;
	ppt_wide_t      diff;
	ppt_wide_t      fwd_dist;
	ppt_wide_t      rev_dist;
	ppt_wide_t      wrap_travel;
	ppt_wide_t      lin_end;
	ppt_wide_t      lin_ref;

	ppt_divu #(
		.W (48)
	) u_div (
		.clk       (clk),
		.rst_b     (rst_b),
		.start     (div_go_reg),
		.dividend  (dividend_reg),
		.divisor   (divisor_reg),
		.done      (div_done),
		.quotient  (div_quo),
		.remainder (div_rem)
	);

	// Shifting by the offset places the window start at zero before folding.
	assign cmd_shift = cmd_l_reg + offs_reg;
	assign tgt_shift = target_l_reg + offs_reg;
	assign folded    = (neg_reg && (div_rem != 48'h0)) ? (range_reg - ppt_wide_t'(div_rem))
	                                                   : ppt_wide_t'(div_rem);

	assign diff     = tgt_in_reg - cur_in_reg;
	assign fwd_dist = (diff < 0) ? (diff + range_reg) : diff;
	assign rev_dist = (fwd_dist == 48'sh0) ? 48'sh0 : (range_reg - fwd_dist);

	always_comb begin
		case (mode_l_reg)
			PPT_WRAP_ABSOLUTE: wrap_travel = diff;
			PPT_WRAP_SHORTEST: wrap_travel = (fwd_dist <= rev_dist) ? fwd_dist : -rev_dist;
			PPT_WRAP_FORWARD:  wrap_travel = fwd_dist;
			default:           wrap_travel = -rev_dist;
		endcase
	end

	// The actual position is taken as reference even if it lags the command one.
	assign lin_ref = base_act_l_reg ? act_l_reg : cmd_l_reg;
	assign lin_end = relative_l_reg ? (lin_ref + target_l_reg) : target_l_reg;

	assign done_set   = (state_reg == PPT_RESULT);
	assign error_set  = (state_reg == PPT_FAIL);
	assign window_set = (state_reg == PPT_TGT) && div_done && (tgt_shift < 0 || tgt_shift >= range_reg);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg      <= PPT_IDLE;
			relative_l_reg <= 1'b0;
			base_act_l_reg <= 1'b0;
			wrap_l_reg     <= 1'b0;
			mode_l_reg     <= PPT_WRAP_ABSOLUTE;
			target_l_reg   <= '0;
			cmd_l_reg      <= '0;
			act_l_reg      <= '0;
			range_reg      <= '0;
			offs_reg       <= '0;
			cur_in_reg     <= '0;
			tgt_in_reg     <= '0;
			neg_reg        <= 1'b0;
			div_go_reg     <= 1'b0;
			dividend_reg   <= '0;
			divisor_reg    <= '0;
		end else begin
			div_go_reg <= 1'b0;
			case (state_reg)
				PPT_IDLE: begin
					if (start_evt) begin
						relative_l_reg <= reg_wdata[`PPT_CTL_RELATIVE];
						base_act_l_reg <= reg_wdata[`PPT_CTL_BASE_ACTUAL];
						wrap_l_reg     <= reg_wdata[`PPT_CTL_WRAP];
						mode_l_reg     <= wrap_mode_reg;
						target_l_reg   <= ppt_wide_t'(signed'(target_reg));
						cmd_l_reg      <= ppt_wide_t'(signed'(cmd_pos));
						act_l_reg      <= ppt_wide_t'(signed'(act_pos));
						if (!reg_wdata[`PPT_CTL_WRAP]) begin
							state_reg <= PPT_RESULT;
						end else if (!wrap_enable_reg || wrap_range_reg == 16'h0000) begin
							state_reg <= PPT_FAIL;
						end else begin
							// Range in steps is the setting in tenths of a turn.
							dividend_reg <= 48'(wrap_range_reg) * 48'(STEPS_PER_REV);
							divisor_reg  <= `PPT_RANGE_DIVISOR;
							div_go_reg   <= 1'b1;
							state_reg    <= PPT_RANGE;
						end
					end
				end
				PPT_RANGE: begin
					if (div_done) begin
						range_reg <= ppt_wide_t'(div_quo);
						if (div_quo == 48'h0) begin
							state_reg <= PPT_FAIL;
						end else begin
							dividend_reg <= div_quo * 48'(wrap_offset_reg);
							divisor_reg  <= `PPT_RATIO_DIVISOR;
							div_go_reg   <= 1'b1;
							state_reg    <= PPT_OFFS;
						end
					end
				end
				PPT_OFFS: begin
					if (div_done) begin
						offs_reg     <= ppt_wide_t'(div_quo);
						neg_reg      <= (cmd_l_reg + ppt_wide_t'(div_quo)) < 0;
						dividend_reg <= 48'((cmd_l_reg + ppt_wide_t'(div_quo)) < 0
						                    ? -(cmd_l_reg + ppt_wide_t'(div_quo))
						                    : (cmd_l_reg + ppt_wide_t'(div_quo)));
						divisor_reg  <= 48'(range_reg);
						div_go_reg   <= 1'b1;
						state_reg    <= PPT_CUR;
					end
				end
				PPT_CUR: begin
					if (div_done) begin
						cur_in_reg   <= folded;
						neg_reg      <= tgt_shift < 0;
						dividend_reg <= 48'((tgt_shift < 0) ? -tgt_shift : tgt_shift);
						div_go_reg   <= 1'b1;
						state_reg    <= PPT_TGT;
					end
				end
				PPT_TGT: begin
					if (div_done) begin
						tgt_in_reg <= folded;
						state_reg  <= PPT_RESULT;
					end
				end
				PPT_RESULT: begin
					state_reg <= PPT_IDLE;
				end
				default: begin
					state_reg <= PPT_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Move outputs
	// ------------------------------------------------------------------
	ppt_wide_t end_calc;
	ppt_wide_t trav_calc;

	// A wrap move always counts from the command position and ignores the relative bit.
	assign end_calc  = wrap_l_reg ? (cmd_l_reg + wrap_travel) : lin_end;
	assign trav_calc = end_calc - cmd_l_reg;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			move_start      <= 1'b0;
			move_endpoint   <= 32'h0000_0000;
			move_travel     <= 32'h0000_0000;
			move_forward    <= 1'b0;
			move_push       <= 1'b0;
			move_rebase     <= 1'b0;
			move_rebase_pos <= 32'h0000_0000;
		end else begin
			move_start  <= 1'b0;
			move_rebase <= 1'b0;
			if (state_reg == PPT_RESULT) begin
				move_start      <= 1'b1;
				move_endpoint   <= end_calc[31:0];
				move_travel     <= trav_calc[31:0];
				move_forward    <= wrap_l_reg ? (wrap_travel > 0) : (trav_calc > 0);
				move_push       <= control_reg[`PPT_CTL_PUSH];
				// Command position is re-based on the actual one so both end together.
				move_rebase     <= !wrap_l_reg && relative_l_reg && base_act_l_reg;
				move_rebase_pos <= act_l_reg[31:0];
			end
		end
	end

	assign move_busy = (state_reg != PPT_IDLE);

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			if (reg_addr == `PPT_OFF_CONTROL) begin
				reg_rdata <= {16'h0000, control_reg};
			end else if (reg_addr == `PPT_OFF_TARGET) begin
				reg_rdata <= target_reg;
			end else if (reg_addr == `PPT_OFF_WRAP_MODE) begin
				reg_rdata <= {30'h0000_0000, wrap_mode_reg};
			end else if (reg_addr == `PPT_OFF_WRAP_ENABLE) begin
				reg_rdata <= {31'h0000_0000, wrap_enable_reg};
			end else if (reg_addr == `PPT_OFF_WRAP_RANGE) begin
				reg_rdata <= {16'h0000, wrap_range_reg};
			end else if (reg_addr == `PPT_OFF_WRAP_OFFSET) begin
				reg_rdata <= {16'h0000, wrap_offset_reg};
			end else if (reg_addr == `PPT_OFF_STATUS) begin
				reg_rdata <= {26'h000_0000, move_rebase_pos == act_l_reg[31:0] && base_act_l_reg,
				              out_window_reg, error_reg, move_forward, done_reg, move_busy};
			end else if (reg_addr == `PPT_OFF_ENDPOINT) begin
				reg_rdata <= move_endpoint;
			end else if (reg_addr == `PPT_OFF_TRAVEL) begin
				reg_rdata <= move_travel;
			end else begin
				reg_rdata <= 32'h0000_0000;
			end
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule : ppt_core

// ### verif/ppt_core_monitor.sv
`timescale 1ns/10ps

module ppt_core_monitor (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [31:0] cmd_pos,
	input wire logic [31:0] act_pos,
	input wire logic        move_start,
	input wire logic [31:0] move_endpoint,
	input wire logic [31:0] move_travel,
	input wire logic        move_forward,
	input wire logic        move_rebase,
	input wire logic [31:0] move_rebase_pos,
	input wire logic        move_busy
);
	import ppt_pkg::*;

	// ------------------------------------------------------------
	// Shadow registers
	// ------------------------------------------------------------
	// The checker keeps its own copy of what software wrote, so a stale
	// latch inside the design cannot hide behind its own register.
	logic        ctl4_reg;
	logic [1:0]  mode_reg;
	logic [31:0] tgt_reg;
	logic        wrap_lat_reg;
	logic        rel_lat_reg;
	logic        base_lat_reg;
	logic [1:0]  mode_lat_reg;
	logic [31:0] tgt_lat_reg;
	logic [31:0] cmd_lat_reg;
	logic [31:0] act_lat_reg;
	wire logic   req = reg_wr && reg_addr == 8'h00 && reg_wdata[4] && !ctl4_reg && !move_busy;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctl4_reg <= 1'b0;
			mode_reg <= 2'h0;
			tgt_reg  <= 32'h0;
		end else if (reg_wr) begin
			if (reg_addr == 8'h00) ctl4_reg <= reg_wdata[4];
			if (reg_addr == 8'h04) tgt_reg <= reg_wdata;
			if (reg_addr == 8'h08) mode_reg <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (req) begin
			wrap_lat_reg <= reg_wdata[14];
			rel_lat_reg  <= reg_wdata[6];
			base_lat_reg <= reg_wdata[12];
			mode_lat_reg <= mode_reg;
			tgt_lat_reg  <= tgt_reg;
			cmd_lat_reg  <= cmd_pos;
			act_lat_reg  <= act_pos;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read cycle");

	property p_start_lat;
		req && !reg_wdata[14] |-> ##2 move_start;
	endproperty
	a_start_lat: assert property (p_start_lat) else $error("move start late or missing");

	property p_busy_end;
		$rose(move_busy) |-> ##[1:300] !move_busy;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy never falls");

	property p_travel;
		move_start |-> move_travel == move_endpoint - cmd_lat_reg;
	endproperty
	a_travel: assert property (p_travel) else $error("travel not endpoint minus command");

	property p_dir;
		move_start |-> move_forward == (!move_travel[31] && move_travel != 32'h0);
	endproperty
	a_dir: assert property (p_dir) else $error("direction disagrees with travel");

	property p_abs;
		move_start && !wrap_lat_reg && !rel_lat_reg |-> move_endpoint == tgt_lat_reg;
	endproperty
	a_abs: assert property (p_abs) else $error("absolute endpoint wrong");

	property p_rel_cmd;
		move_start && !wrap_lat_reg && rel_lat_reg && !base_lat_reg
			|-> move_endpoint == cmd_lat_reg + tgt_lat_reg && !move_rebase;
	endproperty
	a_rel_cmd: assert property (p_rel_cmd) else $error("command based endpoint wrong");

	property p_rel_act;
		move_start && !wrap_lat_reg && rel_lat_reg && base_lat_reg |-> move_rebase
			&& move_rebase_pos == act_lat_reg && move_endpoint == act_lat_reg + tgt_lat_reg;
	endproperty
	a_rel_act: assert property (p_rel_act) else $error("actual based move wrong");

	property p_fwd;
		move_start && wrap_lat_reg && mode_lat_reg == PPT_WRAP_FORWARD |-> !move_travel[31];
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward wrap move travels backward");

	property p_rev;
		move_start && wrap_lat_reg && mode_lat_reg == PPT_WRAP_REVERSE |-> move_travel[31] || move_travel == 32'h0;
	endproperty
	a_rev: assert property (p_rev) else $error("reverse wrap move travels forward");
endmodule : ppt_core_monitor

// ### verif/ppt_axis_model.sv
`timescale 1ns/10ps

module ppt_axis_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        load,
	input  wire logic [31:0] load_cmd,
	input  wire logic [31:0] load_act,
	input  wire logic        move_start,
	input  wire logic [31:0] move_endpoint,
	output logic      [31:0] cmd_pos,
	output logic      [31:0] act_pos
);
	// Moves finish at once with no following error, so only a load can open
	// a gap between command and actual position, as a stalled push would.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cmd_pos <= 32'h0;
			act_pos <= 32'h0;
		end else if (load) begin
			cmd_pos <= load_cmd;
			act_pos <= load_act;
		end else if (move_start) begin
			cmd_pos <= move_endpoint;
			act_pos <= move_endpoint;
		end
	end
endmodule : ppt_axis_model

// ### verif/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
	import ppt_pkg::*;

	typedef struct packed {
		logic [15:0] ctl;
		logic [31:0] tgt;
		logic [1:0]  mode;
		logic [31:0] cmd;
		logic [31:0] act;
		logic [31:0] endp;
		logic        fwd;
	} ppt_row_t;

	logic        clk       = 1'b0;
	logic        rst_b     = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        load      = 1'b0;
	logic [31:0] load_cmd  = 32'h0;
	logic [31:0] load_act  = 32'h0;
	logic [31:0] reg_rdata, cmd_pos, act_pos, move_endpoint, move_travel, move_rebase_pos;
	logic        move_start, move_forward, move_push, move_rebase, move_busy;
	int          mismatches = 0;
	int          n_compared = 0;
	ppt_row_t    rows [9];
	logic [7:0]  rst_addr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24};
	logic [31:0] rst_val [7]  = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_000a, 32'h0000_1388, 32'h0};

	ppt_core DUT (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_pos(cmd_pos), .act_pos(act_pos),
		.move_start(move_start), .move_endpoint(move_endpoint), .move_travel(move_travel),
		.move_forward(move_forward), .move_push(move_push), .move_rebase(move_rebase),
		.move_rebase_pos(move_rebase_pos), .move_busy(move_busy)
	);

	ppt_axis_model u_axis (
		.clk(clk), .rst_b(rst_b), .load(load), .load_cmd(load_cmd), .load_act(load_act),
		.move_start(move_start), .move_endpoint(move_endpoint), .cmd_pos(cmd_pos), .act_pos(act_pos)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic summarize();
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic wait_idle();
		int i;
		@(posedge clk);
		#1;
		for (i = 0; i < 400 && move_busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 400) begin
			mismatches++;
			summarize();
		end
	endtask : wait_idle

	// ------------------------------------------------------------
	// One move: place the axis, program, start, then read back
	// ------------------------------------------------------------
	task automatic run_row(input ppt_row_t r);
		logic [31:0] v;
		@(posedge clk);
		load     <= 1'b1;
		load_cmd <= r.cmd;
		load_act <= r.act;
		@(posedge clk);
		load <= 1'b0;
		wr(8'h04, r.tgt);
		wr(8'h08, {30'h0, r.mode});
		wr(8'h00, 32'h0);
		wr(8'h00, {16'h0, r.ctl});
		wait_idle();
		rd(8'h1c, v);
		`CHK("endpoint", r.endp, v)
		rd(8'h20, v);
		`CHK("travel", r.endp - r.cmd, v)
		`CHK("forward", r.fwd, move_forward)
		`CHK("push", r.ctl[13], move_push)
	endtask : run_row

	initial begin
		logic [31:0] v;
		rows = '{
			'{16'h0010, 32'sh0fa0, 2'h0, 32'sh03e8, 32'sh03e8, 32'sh0fa0, 1'b1},
			'{16'h2050, 32'sh0bb8, 2'h0, 32'sh03e8, 32'sh0384, 32'sh0fa0, 1'b1},
			'{16'h1050, 32'sh0bb8, 2'h0, 32'sh03e8, 32'sh0384, 32'sh0f3c, 1'b1},
			'{16'h0050, -32'sh01f4, 2'h0, 32'sh00c8, 32'sh00c8, -32'sh012c, 1'b0},
			'{16'h4050, 32'sh0fa0, 2'h0, 32'sh03e8, 32'sh03e8, 32'sh0fa0, 1'b1},
			'{16'h4010, -32'sh0fa0, 2'h0, 32'sh03e8, 32'sh03e8, -32'sh0fa0, 1'b0},
			'{16'h4010, 32'sh0fa0, 2'h1, -32'sh0fa0, -32'sh0fa0, -32'sh1770, 1'b0},
			'{16'h4010, -32'sh0fa0, 2'h2, 32'sh03e8, 32'sh03e8, 32'sh1770, 1'b1},
			'{16'h4010, 32'sh0fa0, 2'h3, 32'sh03e8, 32'sh03e8, -32'sh1770, 1'b0}
		};
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		wr(8'h0c, 32'h1);
		foreach (rows[k]) run_row(rows[k]);
		// ------------------------------------------------------------
		// Reset in mid-run, defaults and an unmapped address
		// ------------------------------------------------------------
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		foreach (rst_addr[k]) begin
			rd(rst_addr[k], v);
			`CHK("reset value", rst_val[k], v)
		end
		// Wrap requested while wrap is still disabled must be refused.
		wr(8'h00, 32'h0000_4010);
		wait_idle();
		rd(8'h18, v);
		`CHK("error flag", 1'b1, v[3])
		// Two revolutions with a quarter offset: window runs from -5000 to 15000.
		wr(8'h0c, 32'h1);
		wr(8'h10, 32'h0000_0014);
		wr(8'h14, 32'h0000_09c4);
		run_row('{16'h4010, 32'sh2ee0, 2'h2, 32'sh36b0, 32'sh36b0, 32'sh7d00, 1'b1});
		rd(8'h18, v);
		`CHK("done flag", 1'b1, v[1])
		`CHK("window flag", 1'b0, v[4])
		// A target past the window end is still folded into it and moved to, but flagged.
		run_row('{16'h4010, 32'sh3e80, 2'h0, 32'sh0, 32'sh0, -32'sh0fa0, 1'b0});
		rd(8'h18, v);
		`CHK("window flag", 1'b1, v[4])
		wr(8'h18, 32'h0000_0010);
		rd(8'h18, v);
		`CHK("window flag cleared", 1'b0, v[4])
		summarize();
	end
endmodule : testbench

bind ppt_core ppt_core_monitor u_mon (
	.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_pos(cmd_pos), .act_pos(act_pos),
	.move_start(move_start), .move_endpoint(move_endpoint), .move_travel(move_travel),
	.move_forward(move_forward), .move_rebase(move_rebase), .move_rebase_pos(move_rebase_pos),
	.move_busy(move_busy)
);
